/* File: hw/dcs_top.sv */
/*
 * dcs_top: converter control logic with a code fifo toward the analog
 * core; dcs_fifo: parameterised fifo with registered head.
 * assumes: bus and event network on ref_clk_in; start event and the
 * low-voltage level arrive asynchronously and are synchronised here.
 */
// Overview of operation
// - standby_keep set holds output buffer in standby; clear turns it off
// - converter clock keeps running during idle sleep
// - synchronised write raises busy at once, drops it when crossing ends
// - synchronised write while busy is dropped and answered with error
// - soft reset, enable, conversion and staged writes are synchronised
// - staged and conversion registers form a queue moved by start event
// - start event with staged register empty sets the underrun flag
// - staged register emptied emits empty event and empty flag
// - internal route bit sends output to comparator, alongside pin drive
// - pump runs at low voltage unless pump_off forces it off
// - bus accepts 8, 16 and 32 bit accesses and byte halves
// - enable reads back at once, applied on the same edge that clears busy
// - soft reset restores every register and disables the converter
// - a write setting soft reset discards all its other bits
// - soft reset bit reads one until the synchronised reset ends
// - analog and event config writable only while enable is zero
// - ref_choice: 0 internal, 1 analog supply, 2 external pin, 3 reserved
// - standby_keep writes take effect directly without synchronising
// - msb_align selects left- or right-aligned 10 bit samples
// - empty flag set on queue move, cleared by one or staged write
// - start events synchronised; rising edge, falling when inverted
// - any new conversion value starts a conversion
`timescale 1ns/100ps

module dcs_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32
) (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
        logic head_v;
        logic [WIDTH-1:0] head;
    } dcs_fifo_s;
    dcs_fifo_s f_reg, f_next;
    logic push;
    logic pop;

    assign in_ready_out = (f_reg.cnt != (AW+1)'(DEPTH));
    assign out_valid_out = f_reg.head_v;
    assign out_data_out = f_reg.head;

    always_comb begin
        f_next = f_reg;
        push = in_valid_in && in_ready_out;
        pop = (f_reg.cnt != '0) && (!f_reg.head_v || out_ready_in);
        if (out_ready_in) begin
            f_next.head_v = 1'b0;
        end
        if (pop) begin
            f_next.head = f_reg.mem[f_reg.rd];
            f_next.head_v = 1'b1;
            f_next.rd = f_reg.rd + 1'b1;
        end
        if (push) begin
            f_next.mem[f_reg.wr] = in_data_in;
            f_next.wr = f_reg.wr + 1'b1;
        end
        f_next.cnt = f_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            f_reg <= '0;
        end else begin
            f_reg <= f_next;
        end
    end
endmodule : dcs_fifo

module dcs_top import dcs_pkg::*; #(
    parameter int SYNC_LEN = SYNC_CYCLES,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic start_event_in,
    input wire logic low_voltage_in,
    input wire logic idle_sleep_in,
    input wire logic standby_sleep_in,
    output logic empty_event_out,
    output logic irq_out,
    output logic [CODE_W-1:0] code_out,
    output logic code_valid_out,
    input wire logic code_ready_in,
    output logic [1:0] ref_choice_out,
    output logic out_buffer_on_out,
    output logic internal_route_out,
    output logic pump_on_out,
    output logic conv_clock_run_out,
    output logic conv_enabled_out
);
    typedef struct packed {
        logic keep;
        logic en_bit;
        logic soft_reset_bit;
        logic enabled;
        logic [7:0] aconf;
        logic [2:0] evcfg;
        logic [2:0] inten;
        logic [2:0] flags;
        logic [15:0] conv;
        logic [15:0] staged;
        logic staged_full;
        logic busy;
        logic [3:0] cnt;
        dcs_op_e op;
        logic [15:0] op_val;
        logic start_pend;
        logic evt_s1;
        logic evt_s2;
        logic evt_prev;
        logic lv_s1;
        logic lv_s2;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic empty_evt;
        logic irq;
        logic o_buf;
        logic o_route;
        logic o_pump;
        logic o_clk;
    } dcs_state_s;
    dcs_state_s s_reg, s_next;
    logic push_v;
    logic [CODE_W-1:0] push_d;
    logic fifo_ready;
    logic setup;
    logic edge_seen;
    logic [15:0] merged;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [CODE_W-1:0] align_code(
        input logic [15:0] v, input logic left);
        align_code = left ? v[15:6] : v[9:0];
    endfunction : align_code

    function automatic logic [15:0] lane_merge(
        input logic [15:0] old, input logic [15:0] w, input logic [1:0] st);
        lane_merge = {st[1] ? w[15:8] : old[15:8], st[0] ? w[7:0] : old[7:0]};
    endfunction : lane_merge

    function automatic logic [31:0] read_word(
        input dcs_state_s s, input logic [1:0] idx);
        case (idx)
            2'd0: read_word = {8'h00, 5'h00, s.evcfg, s.aconf,
                               5'h00, s.keep, s.en_bit, s.soft_reset_bit};
            2'd1: read_word = {s.busy, 7'h00, 5'h00, s.flags,
                               5'h00, s.inten, 5'h00, s.inten};
            2'd2: read_word = {16'h0000, s.conv};
            default: read_word = {16'h0000, s.staged};
        endcase
    endfunction : read_word

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        push_v = 1'b0;
        push_d = '0;
        merged = '0;
        setup = psel_in && !penable_in;
        s_next.pready = setup;
        s_next.pslverr = 1'b0;
        s_next.empty_evt = 1'b0;
        s_next.evt_s1 = start_event_in;
        s_next.evt_s2 = s_reg.evt_s1;
        s_next.evt_prev = s_reg.evt_s2;
        s_next.lv_s1 = low_voltage_in;
        s_next.lv_s2 = s_reg.lv_s1;
        // edge on the synchronised start event
        edge_seen = s_reg.evcfg[BIT_INVERT_EVENT_IN] ?
            (!s_reg.evt_s2 && s_reg.evt_prev) :
            (s_reg.evt_s2 && !s_reg.evt_prev);

        // bus access, acted on in the setup phase
        if (setup) begin
            s_next.prdata = read_word(s_reg, paddr_in[3:2]);
            if (paddr_in[11:4] != 8'h00) begin
                s_next.pslverr = 1'b1;
                s_next.prdata = '0;
            end else if (pwrite_in) begin
                s_next.prdata = '0;
                case (paddr_in[3:2])
                    2'd0: begin
                        if (pstrb_in[0]) begin
                            if (s_reg.busy) begin
                                s_next.pslverr = 1'b1;
                            end else if (pwdata_in[BIT_SOFT_RESET]) begin
                                s_next.soft_reset_bit = 1'b1;
                                s_next.busy = 1'b1;
                                s_next.op = DCS_OP_SOFT_RESET_BIT;
                                s_next.cnt = 4'(SYNC_LEN);
                            end else begin
                                s_next.en_bit = pwdata_in[BIT_ENABLE];
                                s_next.busy = 1'b1;
                                s_next.op = DCS_OP_ENABLE;
                                s_next.cnt = 4'(SYNC_LEN);
                            end
                            if (!pwdata_in[BIT_SOFT_RESET]) begin
                                s_next.keep = pwdata_in[BIT_STANDBY_KEEP];
                            end
                        end
                        if (!(pstrb_in[0] && pwdata_in[BIT_SOFT_RESET])
                            && !s_reg.en_bit) begin
                            if (pstrb_in[1]) begin
                                s_next.aconf = pwdata_in[15:8];
                            end
                            if (pstrb_in[2]) begin
                                s_next.evcfg = pwdata_in[18:16];
                            end
                        end
                    end
                    2'd1: begin
                        if (pstrb_in[0]) begin
                            s_next.inten = s_next.inten & ~pwdata_in[2:0];
                        end
                        if (pstrb_in[1]) begin
                            s_next.inten = s_next.inten | pwdata_in[10:8];
                        end
                        if (pstrb_in[2]) begin
                            s_next.flags = s_reg.flags & ~pwdata_in[18:16];
                        end
                    end
                    default: begin
                        if (pstrb_in[1:0] != 2'b00) begin
                            if (s_reg.busy) begin
                                s_next.pslverr = 1'b1;
                            end else begin
                                merged = lane_merge(paddr_in[2] ?
                                    s_reg.staged : s_reg.conv,
                                    pwdata_in[15:0], pstrb_in[1:0]);
                                s_next.op_val = merged;
                                s_next.busy = 1'b1;
                                s_next.cnt = 4'(SYNC_LEN);
                                s_next.op = paddr_in[2] ?
                                    DCS_OP_STAGED : DCS_OP_DATA;
                            end
                        end
                    end
                endcase
            end
        end

        // start event handling
        if (edge_seen && s_reg.enabled
            && s_reg.evcfg[BIT_START_EVENT_IN]) begin
            if (s_reg.staged_full) begin
                s_next.start_pend = 1'b1;
            end else if (!s_reg.start_pend) begin
                s_next.flags[BIT_UNDERRUN] = 1'b1;
            end
        end

        // synchronised operation completes
        if (s_reg.busy) begin
            if (s_reg.cnt > 4'd1) begin
                s_next.cnt = s_reg.cnt - 4'd1;
            end else if (s_reg.op != DCS_OP_DATA || fifo_ready) begin
                s_next.busy = 1'b0;
                s_next.flags[BIT_SYNC_DONE] = 1'b1;
                case (s_reg.op)
                    DCS_OP_ENABLE: s_next.enabled = s_reg.en_bit;
                    DCS_OP_DATA: begin
                        s_next.conv = s_reg.op_val;
                        push_v = 1'b1;
                        push_d = align_code(s_reg.op_val,
                            s_reg.aconf[BIT_MSB_ALIGN]);
                    end
                    DCS_OP_STAGED: begin
                        s_next.staged = s_reg.op_val;
                        s_next.staged_full = 1'b1;
                        s_next.flags[BIT_EMPTY] = 1'b0;
                    end
                    default: begin
                        s_next.keep = RST_MAIN_CONTROL[BIT_STANDBY_KEEP];
                        s_next.en_bit = RST_MAIN_CONTROL[BIT_ENABLE];
                        s_next.soft_reset_bit = 1'b0;
                        s_next.enabled = 1'b0;
                        s_next.aconf = RST_ANALOG_CONFIG;
                        s_next.evcfg = RST_EVENT_CONFIG;
                        s_next.inten = RST_IRQ;
                        s_next.flags = RST_IRQ;
                        s_next.conv = RST_VALUE;
                        s_next.staged = RST_VALUE;
                        s_next.staged_full = 1'b0;
                        s_next.start_pend = 1'b0;
                    end
                endcase
            end
        end

        // queue move: staged value into conversion register
        if (s_reg.start_pend && !push_v && fifo_ready
            && !(s_reg.busy && s_reg.op == DCS_OP_SOFT_RESET_BIT)) begin
            s_next.start_pend = 1'b0;
            s_next.conv = s_reg.staged;
            s_next.staged_full = 1'b0;
            s_next.flags[BIT_EMPTY] = 1'b1;
            s_next.empty_evt = s_reg.evcfg[BIT_EMPTY_EVENT_OUT];
            push_v = 1'b1;
            push_d = align_code(s_reg.staged, s_reg.aconf[BIT_MSB_ALIGN]);
        end

        // registered outputs
        s_next.irq = |(s_next.flags & s_next.inten);
        s_next.o_buf = s_next.enabled && s_next.aconf[BIT_EXTERNAL_DRIVE]
            && (!standby_sleep_in || s_next.keep);
        s_next.o_route = s_next.enabled
            && s_next.aconf[BIT_INTERNAL_ROUTE];
        s_next.o_pump = s_next.enabled && s_reg.lv_s2
            && !s_next.aconf[BIT_PUMP_OFF];
        s_next.o_clk = s_next.enabled
            && (idle_sleep_in || !standby_sleep_in);
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // code fifo toward the analog core
    // ------------------------------------------------------------
    dcs_fifo #(.WIDTH(CODE_W), .DEPTH(DEPTH)) u_fifo (
        .ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .in_valid_in(push_v),
        .in_data_in(push_d),
        .in_ready_out(fifo_ready),
        .out_valid_out(code_valid_out),
        .out_data_out(code_out),
        .out_ready_in(code_ready_in)
    );

    assign prdata_out = s_reg.prdata;
    assign pready_out = s_reg.pready;
    assign pslverr_out = s_reg.pslverr;
    assign empty_event_out = s_reg.empty_evt;
    assign irq_out = s_reg.irq;
    assign ref_choice_out = s_reg.aconf[BIT_REF_LO+1:BIT_REF_LO];
    assign out_buffer_on_out = s_reg.o_buf;
    assign internal_route_out = s_reg.o_route;
    assign pump_on_out = s_reg.o_pump;
    assign conv_clock_run_out = s_reg.o_clk;
    assign conv_enabled_out = s_reg.enabled;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_sync_write;
        setup && pwrite_in && paddr_in[11:4] == 8'h00 && !s_reg.busy
        && paddr_in[3] && pstrb_in[0];
    endsequence
    sequence s_busy_run;
        s_reg.busy [*2];
    endsequence
    property p_busy_rise;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        s_sync_write |=> s_busy_run;
    endproperty
    a_busy_rise: assert property (p_busy_rise)
        else $error("busy not raised by synchronised write");
    property p_discard;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (setup && pwrite_in && s_reg.busy && paddr_in[11:3] == 9'h001
         && pstrb_in[0]) |=> (pslverr_out && $stable(s_reg.op_val));
    endproperty
    a_discard: assert property (p_discard)
        else $error("write during busy not refused");
    property p_underrun;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (edge_seen && s_reg.enabled && s_reg.evcfg[BIT_START_EVENT_IN]
         && !s_reg.staged_full && !s_reg.start_pend)
        |=> s_reg.flags[BIT_UNDERRUN];
    endproperty
    a_underrun: assert property (p_underrun)
        else $error("underrun flag missing");
    property p_empty_evt;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        empty_event_out |-> (s_reg.flags[BIT_EMPTY] && !s_reg.staged_full
            && s_reg.evcfg[BIT_EMPTY_EVENT_OUT]);
    endproperty
    a_empty_evt: assert property (p_empty_evt)
        else $error("empty event without empty buffer");
    property p_irq;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        irq_out == |(s_reg.flags & s_reg.inten);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt output mismatch");
    property p_soft_reset_bit_busy;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        s_reg.soft_reset_bit |-> (s_reg.busy && s_reg.op == DCS_OP_SOFT_RESET_BIT);
    endproperty
    a_soft_reset_bit_busy: assert property (p_soft_reset_bit_busy)
        else $error("soft reset bit set without busy");
    property p_protect;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        ($past(s_reg.en_bit) && s_reg.en_bit) |-> $stable(s_reg.aconf);
    endproperty
    a_protect: assert property (p_protect)
        else $error("analog config changed while enabled");
    property p_route;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        internal_route_out |-> (s_reg.enabled
            && s_reg.aconf[BIT_INTERNAL_ROUTE]);
    endproperty
    a_route: assert property (p_route)
        else $error("internal route without its bit");
    property p_enable_apply;
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (s_reg.busy && s_reg.op == DCS_OP_ENABLE && s_reg.cnt == 4'd1)
        |=> (conv_enabled_out == s_reg.en_bit && !s_reg.busy);
    endproperty
    a_enable_apply: assert property (p_enable_apply)
        else $error("enable not applied at end of sync");
endmodule : dcs_top

/* File: hw/dcs_pkg.sv */
/*
 * dcs_pkg: register map, field positions, reset values and timing
 * constants of the converter control block.
 * assumes: byte-addressed register bus, 100 MHz reference clock.
 */
package dcs_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_MAIN_CONTROL = 12'h000;
    localparam logic [11:0] OFS_ANALOG_CONFIG = 12'h001;
    localparam logic [11:0] OFS_EVENT_CONFIG = 12'h002;
    localparam logic [11:0] OFS_IRQ_ENABLE_CLEAR = 12'h004;
    localparam logic [11:0] OFS_IRQ_ENABLE_SET = 12'h005;
    localparam logic [11:0] OFS_IRQ_FLAGS = 12'h006;
    localparam logic [11:0] OFS_SYNC_STATUS = 12'h007;
    localparam logic [11:0] OFS_CONVERSION_VALUE = 12'h008;
    localparam logic [11:0] OFS_STAGED_VALUE = 12'h00C;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_SOFT_RESET = 0;
    localparam int BIT_ENABLE = 1;
    localparam int BIT_STANDBY_KEEP = 2;
    localparam int BIT_EXTERNAL_DRIVE = 0;
    localparam int BIT_INTERNAL_ROUTE = 1;
    localparam int BIT_MSB_ALIGN = 2;
    localparam int BIT_PUMP_OFF = 3;
    localparam int BIT_REF_LO = 6;
    localparam int BIT_START_EVENT_IN = 0;
    localparam int BIT_EMPTY_EVENT_OUT = 1;
    localparam int BIT_INVERT_EVENT_IN = 2;
    localparam int BIT_UNDERRUN = 0;
    localparam int BIT_EMPTY = 1;
    localparam int BIT_SYNC_DONE = 2;
    localparam int BIT_SYNC_PENDING = 7;
    // ------------------------------------------------------------
    // reset values and reference choices
    // ------------------------------------------------------------
    localparam logic [7:0] RST_MAIN_CONTROL = 8'h00;
    localparam logic [7:0] RST_ANALOG_CONFIG = 8'h00;
    localparam logic [2:0] RST_EVENT_CONFIG = 3'h0;
    localparam logic [2:0] RST_IRQ = 3'h0;
    localparam logic [15:0] RST_VALUE = 16'h0000;
    localparam logic [1:0] REF_INTERNAL_FIXED = 2'h0;
    localparam logic [1:0] REF_ANALOG_SUPPLY = 2'h1;
    localparam logic [1:0] REF_EXTERNAL_PIN = 2'h2;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SYNC_TIME_NS = 30;
    localparam int SYNC_CYCLES =
        (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CODE_W = 10;
    localparam int FIFO_DEPTH = 32;

    typedef enum logic [1:0] {
        DCS_OP_ENABLE = 2'b00,
        DCS_OP_SOFT_RESET_BIT = 2'b01,
        DCS_OP_DATA = 2'b10,
        DCS_OP_STAGED = 2'b11
    } dcs_op_e;
endpackage : dcs_pkg

/* File: bench/dcs_core_model.sv */
/*
 * dcs_core_model: analog core side of the code fifo.
 * assumes: codes taken on ref_clk_in when valid and ready are both high.
 */
`timescale 1ns/100ps
// ------------------------------------------------------------
// code sink, prompt or slow
// ------------------------------------------------------------
module dcs_core_model #(
    parameter bit SLOW = 1'b0
) (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic code_valid_in,
    input wire logic [9:0] code_in,
    output logic code_ready_out,
    output logic [9:0] last_code_out
);
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            code_ready_out <= 1'b0;
            last_code_out <= 10'h000;
        end else begin
            code_ready_out <= SLOW ? !code_ready_out : 1'b1;
            if (code_valid_in && code_ready_out) begin
                last_code_out <= code_in;
            end
        end
    end
endmodule : dcs_core_model

/* File: bench/dac_controller_sync_buffer_tb.sv */
/*
 * testbench: register table, sync writes, queue and soft reset.
 * assumes: default sync length of 3 cycles, 100 MHz clock.
 */
`timescale 1ns/100ps
module dac_controller_sync_buffer_tb import dcs_pkg::*;;
    typedef struct {logic [11:0] a; logic [31:0] d; logic e;} dcs_row_s;
    logic ref_clk_in, resetn_in, psel_in, penable_in, pwrite_in;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, rd;
    logic [3:0] pstrb_in;
    logic pready_out, pslverr_out, start_event_in, empty_event_out, irq_out;
    logic [CODE_W-1:0] code_out, last_code;
    logic code_valid_out, code_ready_in, conv_enabled_out, er;
    logic [1:0] ref_choice_out;
    logic lv = 1'b1, idle = 1'b0, stby = 1'b0;
    logic buf_on, route_on, pump_on, clk_run;
    int err_count = 0, num_checks = 0, ev_count = 0;
    dcs_row_s rows [5] = '{'{12'h000, 32'h0, 1'b0}, '{12'h004, 32'h0, 1'b0},
        '{12'h008, 32'h0, 1'b0}, '{12'h00C, 32'h0, 1'b0},
        '{12'h010, 32'h0, 1'b1}};
    dcs_top dut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
        .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .start_event_in(start_event_in),
        .low_voltage_in(lv), .idle_sleep_in(idle),
        .standby_sleep_in(stby), .empty_event_out(empty_event_out),
        .irq_out(irq_out), .code_out(code_out),
        .code_valid_out(code_valid_out), .code_ready_in(code_ready_in),
        .ref_choice_out(ref_choice_out), .out_buffer_on_out(buf_on),
        .internal_route_out(route_on), .pump_on_out(pump_on),
        .conv_clock_run_out(clk_run),
        .conv_enabled_out(conv_enabled_out));
    dcs_core_model #(.SLOW(1'b1)) core (.ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in), .code_valid_in(code_valid_out),
        .code_in(code_out), .code_ready_out(code_ready_in),
        .last_code_out(last_code));
    initial begin
        ref_clk_in = 0;
        forever #5 ref_clk_in = !ref_clk_in;
    end
    always @(posedge ref_clk_in) if (empty_event_out === 1'b1) ev_count++;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] x,
        input logic [31:0] g);
        num_checks++;
        if (g !== x) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        psel_in = 1; pwrite_in = w; paddr_in = a; pwdata_in = d; pstrb_in = s;
        @(posedge ref_clk_in); #1 penable_in = 1;
        while (pready_out !== 1'b1 && n < 8) begin
            @(posedge ref_clk_in); #1 n++;
        end
        chk("pready", 1, pready_out);
        rd = prdata_out; er = pslverr_out;
        @(posedge ref_clk_in); #1 psel_in = 0; penable_in = 0;
        wt(1);
    endtask : bus
    task automatic wt(input int c);
        repeat (c) @(posedge ref_clk_in);
        #1;
    endtask : wt
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report
    initial begin
        #200000 err_count++;
        final_report;
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        resetn_in = 0; psel_in = 0; penable_in = 0; pwrite_in = 0;
        paddr_in = 0; pwdata_in = 0; pstrb_in = 0; start_event_in = 0;
        wt(20);
        resetn_in = 1;
        foreach (rows[i]) begin
            bus(0, rows[i].a, 0, 4'h0);
            chk("read", rows[i].d, rd);
            chk("error", rows[i].e, er);
        end
        $display("test reset done");
        for (int r = 0; r < 3; r++) begin
            bus(1, 12'h000, {16'h0003, r[1:0], 6'h09, 8'h00}, 4'h6);
            wt(1);
            chk("ref", r, ref_choice_out);
        end
        bus(1, 12'h000, 32'h02, 4'h1);
        bus(1, 12'h000, 32'h02, 4'h1);
        chk("busy error", 1, er);
        wt(6);
        chk("enabled", 1, conv_enabled_out);
        chk("buffer", 1, buf_on);
        chk("pump off", 0, pump_on);
        stby = 1;
        wt(2);
        chk("standby buffer", 0, buf_on);
        chk("standby clock", 0, clk_run);
        stby = 0;
        idle = 1;
        wt(2);
        chk("idle clock", 1, clk_run);
        idle = 0;
        bus(1, 12'h000, 32'h0, 4'h2);
        bus(0, 12'h000, 0, 4'h0);
        chk("ctrl", 32'h038902, rd);
        $display("test enable done");
        bus(1, 12'h008, 32'h0155, 4'h3);
        bus(1, 12'h008, 32'h03FF, 4'h3);
        chk("busy error", 1, er);
        wt(12);
        chk("code", 10'h155, last_code);
        bus(1, 12'h00C, 32'h0077, 4'h3);
        wt(6);
        start_event_in = 1;
        wt(12);
        chk("queued code", 10'h077, last_code);
        chk("empty events", 1, ev_count);
        start_event_in = 0;
        wt(4);
        start_event_in = 1;
        wt(10);
        bus(0, 12'h004, 0, 4'h0);
        chk("flags", 8'h07, rd[23:16]);
        chk("irq idle", 0, irq_out);
        bus(1, 12'h004, 32'h0100, 4'h2);
        wt(1);
        chk("irq set", 1, irq_out);
        bus(1, 12'h004, 32'h070000, 4'h4);
        wt(1);
        chk("irq clear", 0, irq_out);
        $display("test queue done");
        bus(1, 12'h000, 32'h07, 4'h1);
        wt(8);
        bus(0, 12'h000, 0, 4'h0);
        chk("soft reset", 0, rd);
        chk("disabled", 0, conv_enabled_out);
        $display("test soft reset done");
        // left-aligned codes, route, pump, falling-edge start
        bus(1, 12'h000, 32'h00050600, 4'h6);
        bus(1, 12'h000, 32'h02, 4'h1);
        wt(4);
        chk("route", 1, route_on);
        chk("pump on", 1, pump_on);
        lv = 0;
        wt(4);
        chk("pump high supply", 0, pump_on);
        bus(1, 12'h008, 32'hD540, 4'h3);
        wt(12);
        chk("left code", 10'h355, last_code);
        start_event_in = 0;
        wt(6);
        bus(0, 12'h004, 0, 4'h0);
        chk("inverted underrun", 8'h05, rd[23:16]);
        $display("test options done");
        final_report;
    end
endmodule : dac_controller_sync_buffer_tb
